// [rtl/ctc_timer.sv]
// CPU timer control: stop/start, reload command, emulation halt modes, prescaler and counter.
// Assumes a plain register port driven on CLOCK and a debug halt level from another domain.
//
// The strobed register port and the placing of the registers were decided locally.
module ctc_timer (
  input  wire logic                       CLOCK,
  input  wire logic                       RESETN,
  input  wire logic [ctc_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [ctc_pkg::DATA_W-1:0] WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  input  wire logic                       DEBUG_HALT,
  output logic      [ctc_pkg::DATA_W-1:0] RDATA,
  output logic                            IRQ,
  output logic                            RUNNING
);
  import ctc_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction : hit

  // The read mux and the field layout only fit these widths, so other values are refused.
  if (CNT_W != 2 * DATA_W) begin : g_cnt_w_check
    $error("counter must be two data words wide");
  end
  if (PSC_W > PSC_LSB - DIVIDE_DOWN_LOW_LSB) begin : g_psc_w_check
    $error("prescale fields overlap");
  end
  if (PSC_LSB + PSC_W > DATA_W) begin : g_psc_fit_check
    $error("prescale count does not fit the register");
  end
  if (EVT_W > DATA_W) begin : g_evt_w_check
    $error("event bits do not fit the register");
  end

  logic [CNT_W-1:0]  tim_q;
  logic [CNT_W-1:0]  period_q;
  logic [PSC_W-1:0]  psc_q;
  logic [PSC_W-1:0]  divide_down_low_q;
  logic              tss_q;
  logic              tif_q;
  logic              tie_q;
  logic              free_q;
  logic              soft_q;
  logic              halt_q;
  logic              dbg_meta_q;
  logic              dbg_q;
  logic [EVT_W-1:0]  evt_q;
  logic [EVT_W-1:0]  mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic              irq_q;
  logic              running_q;

  logic              wr_ctl;
  logic              reload_w;
  logic              run_w;
  logic              tick_w;
  logic              step_w;
  logic [CNT_W-1:0]  tim_next;
  logic              zero_evt;
  logic              halt_evt;
  logic [DATA_W-1:0] rd_mux;

  assign wr_ctl   = WR && hit(ADDR, IDX_CONTROL);
  assign reload_w = wr_ctl && WDATA[CTL_RELOAD];
  assign run_w    = !tss_q && !halt_q;
  assign tick_w   = run_w && (psc_q == PSC_RST);
  // A reload command in the same cycle as an expiry wins; the step is dropped.
  assign step_w   = tick_w && !reload_w;
  assign tim_next = (tim_q == '0) ? period_q : tim_q - 1'b1;
  assign zero_evt = step_w && (tim_next == '0);
  assign halt_evt = run_w && dbg_q && !free_q && (soft_q ? zero_evt : step_w);

  // The breakpoint level comes from the debug domain, so it is synchronised first.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dbg_meta_q <= 1'b0;
      dbg_q      <= 1'b0;
    end else begin
      dbg_meta_q <= DEBUG_HALT;
      dbg_q      <= dbg_meta_q;
    end
  end

  // Control fields written by software.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tss_q  <= 1'b0;
      tie_q  <= 1'b0;
      free_q <= 1'b0;
      soft_q <= 1'b0;
    end else if (wr_ctl) begin
      tss_q  <= WDATA[CTL_STOP];
      tie_q  <= WDATA[CTL_ENABLE];
      free_q <= WDATA[CTL_FREE];
      soft_q <= WDATA[CTL_SOFT];
    end
  end

  // Divide-down and period values.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      divide_down_low_q   <= DIVIDE_DOWN_LOW_RST;
      period_q <= PERIOD_RST;
    end else if (WR) begin
      if (hit(ADDR, IDX_PRESCALE)) begin
        divide_down_low_q <= WDATA[DIVIDE_DOWN_LOW_LSB +: PSC_W];
      end
      if (hit(ADDR, IDX_PERIOD_L)) begin
        period_q[DATA_W-1:0] <= WDATA;
      end
      if (hit(ADDR, IDX_PERIOD_H)) begin
        period_q[CNT_W-1:DATA_W] <= WDATA;
      end
    end
  end

  // Prescale counter: counts down while running, reloads on expiry or on command.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      psc_q <= PSC_RST;
    end else if (reload_w) begin
      psc_q <= divide_down_low_q;
    end else if (tick_w) begin
      psc_q <= divide_down_low_q;
    end else if (run_w) begin
      psc_q <= psc_q - 1'b1;
    end
  end

  // Main counter.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tim_q <= COUNT_RST;
    end else if (reload_w) begin
      tim_q <= period_q;
    end else if (step_w) begin
      tim_q <= tim_next;
    end
  end

  // Zero flag: a new zero event wins over a clear in the same cycle.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tif_q <= 1'b0;
    end else begin
      tif_q <= zero_evt || (tif_q && !(wr_ctl && WDATA[CTL_FLAG]));
    end
  end

  // Emulation halt: the step that causes it is still taken, so in soft stop the
  // zero flag is set in the same edge that halts the timer.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      halt_q <= 1'b0;
    end else if (!dbg_q || free_q) begin
      halt_q <= 1'b0;
    end else if (halt_evt) begin
      halt_q <= 1'b1;
    end
  end

  // Event status, cleared by reading it; a new event wins over the read.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      evt_q <= EVT_RST;
    end else begin
      evt_q[EVT_ZERO] <= zero_evt || (evt_q[EVT_ZERO] && !(RD && hit(ADDR, IDX_EVT_STAT)));
      evt_q[EVT_HALT] <= halt_evt || (evt_q[EVT_HALT] && !(RD && hit(ADDR, IDX_EVT_STAT)));
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      mask_q <= EVT_RST;
    end else if (WR && hit(ADDR, IDX_EVT_MASK)) begin
      mask_q <= WDATA[EVT_W-1:0];
    end
  end

  always_comb begin
    rd_mux = RD_ZERO;
    unique case (ADDR)
      IDX_CONTROL: begin
        rd_mux[CTL_FLAG]   = tif_q;
        rd_mux[CTL_ENABLE] = tie_q;
        rd_mux[CTL_FREE]   = free_q;
        rd_mux[CTL_SOFT]   = soft_q;
        rd_mux[CTL_STOP]   = tss_q;
      end
      IDX_PRESCALE: begin
        rd_mux[PSC_LSB +: PSC_W]  = psc_q;
        rd_mux[DIVIDE_DOWN_LOW_LSB +: PSC_W] = divide_down_low_q;
      end
      IDX_PERIOD_L: rd_mux = period_q[DATA_W-1:0];
      IDX_PERIOD_H: rd_mux = period_q[CNT_W-1:DATA_W];
      IDX_COUNT_L:  rd_mux = tim_q[DATA_W-1:0];
      IDX_COUNT_H:  rd_mux = tim_q[CNT_W-1:DATA_W];
      IDX_EVT_STAT: rd_mux[EVT_W-1:0] = evt_q;
      IDX_EVT_MASK: rd_mux[EVT_W-1:0] = mask_q;
      default:      rd_mux = RD_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= RD ? rd_mux : RD_ZERO;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      irq_q     <= 1'b0;
      running_q <= 1'b0;
    end else begin
      irq_q     <= (tif_q && tie_q) || |(evt_q & mask_q);
      running_q <= run_w;
    end
  end

  assign RDATA   = rdata_q;
  assign IRQ     = irq_q;
  assign RUNNING = running_q;

  // Helper: true only in the first cycle after reset release.
  logic first_q;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_soft_halt: assert property (
    dbg_q && !free_q && soft_q && run_w && zero_evt |=> halt_q && tim_q == '0)
    else $error("soft stop did not halt at zero");
  a_soft_flag: assert property (
    $rose(halt_q) && $past(soft_q) |-> tif_q && $past(zero_evt))
    else $error("soft stop halted without zero flag");
  a_reload_reads: assert property (
    RD && ADDR == IDX_CONTROL |=> RDATA[CTL_RELOAD] == 1'b0)
    else $error("reload bit read as one");
  a_reload_copy: assert property (
    reload_w |=> tim_q == $past(period_q) && psc_q == $past(divide_down_low_q))
    else $error("reload command did not copy values");
  a_stop_bit: assert property (
    wr_ctl && WDATA[CTL_STOP] |=> tss_q && !run_w ##1 running_q == 1'b0)
    else $error("stop write did not halt timer");
  a_start_bit: assert property (
    wr_ctl && !WDATA[CTL_STOP] && !halt_q && !halt_evt |=> !tss_q && run_w)
    else $error("start write did not run timer");
  a_reset_runs: assert property (
    first_q |-> !tss_q && run_w ##1 running_q)
    else $error("timer not running after reset");
  a_hard_halt: assert property (
    dbg_q && !free_q && !soft_q && step_w |=> halt_q ##1
    ($past(reload_w) || ($stable(tim_q) && $stable(psc_q))))
    else $error("hard stop did not halt after decrement");
  a_free_run: assert property (
    free_q && !tss_q |=> !halt_q)
    else $error("free run halted");
  a_zero_flag: assert property (
    zero_evt |=> tif_q ##1 (IRQ || !$past(tie_q)))
    else $error("zero flag or interrupt missing");
  a_prescale: assert property (
    run_w && psc_q != PSC_RST && !reload_w |=> psc_q == $past(psc_q) - 1'b1 && $stable(tim_q))
    else $error("prescaler did not count down");
  a_expiry: assert property (
    step_w && tim_q != '0 |=> psc_q == $past(divide_down_low_q) && tim_q == $past(tim_q) - 1'b1)
    else $error("expiry did not decrement counter");
  a_period_wrap: assert property (
    step_w && tim_q == '0 |=> tim_q == $past(period_q))
    else $error("counter did not reload from period");

  // Read port, flag, event, stop, counter hold and interrupt behaviour.
  a_rdata_idle: assert property (
    !RD |=> RDATA == RD_ZERO)
    else $error("read data present without a read");
  a_tss_read: assert property (
    RD && ADDR == IDX_CONTROL |=> RDATA[CTL_STOP] == $past(tss_q))
    else $error("stop bit read back wrong");
  a_stop_holds: assert property (
    tss_q && !reload_w |=> $stable(tim_q) && $stable(psc_q))
    else $error("stopped timer changed its count");
  a_running_mirror: assert property (
    1'b1 |=> running_q == $past(run_w))
    else $error("running output does not follow timer");
  a_reload_zero_nop: assert property (
    wr_ctl && !WDATA[CTL_RELOAD] && !step_w |=> $stable(tim_q))
    else $error("control write without reload moved counter");
  a_count_hold: assert property (
    !step_w && !reload_w |=> $stable(tim_q))
    else $error("counter moved without a step");
  a_halt_release: assert property (
    !dbg_q |=> !halt_q)
    else $error("emulation halt held without breakpoint");
  a_flag_clear: assert property (
    wr_ctl && WDATA[CTL_FLAG] && !zero_evt |=> !tif_q)
    else $error("zero flag not cleared by write of one");
  a_flag_hold: assert property (
    wr_ctl && !WDATA[CTL_FLAG] && tif_q |=> tif_q)
    else $error("zero flag cleared by write of zero");
  a_evt_clear: assert property (
    RD && ADDR == IDX_EVT_STAT && !zero_evt && !halt_evt |=> evt_q == EVT_RST)
    else $error("event status not cleared by read");
  a_irq_enable: assert property (
    tif_q && tie_q |=> IRQ)
    else $error("enabled zero flag gave no interrupt");
  a_irq_quiet: assert property (
    !(tif_q && tie_q) && !(|(evt_q & mask_q)) |=> !IRQ)
    else $error("interrupt without a cause");

  c_soft_stop: cover property (dbg_q && soft_q && !free_q ##1 $rose(halt_q));
  c_hard_stop: cover property (dbg_q && !soft_q && !free_q ##1 $rose(halt_q));
  c_reload:    cover property (reload_w ##1 run_w);
  c_irq:       cover property ($rose(IRQ));
  c_free_run:  cover property (dbg_q && free_q && step_w);

endmodule : ctc_timer

// [rtl/ctc_pkg.sv]
// Constants for the CPU timer control block: register indices, field positions and reset values.
// Assumes a 16-bit plain register port with word indices, one clock and an active-low reset.
package ctc_pkg;

  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CNT_W      = 32;
  localparam int unsigned PSC_W      = 8;
  localparam int unsigned EVT_W      = 2;

  // Register indices on the plain port.
  localparam logic [ADDR_W-1:0] IDX_CONTROL  = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_PRESCALE = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_PERIOD_L = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_PERIOD_H = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_COUNT_L  = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_COUNT_H  = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_EVT_STAT = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_EVT_MASK = 4'h7;

  // Control register fields.
  localparam int unsigned CTL_FLAG   = 15;
  localparam int unsigned CTL_ENABLE = 14;
  localparam int unsigned CTL_FREE   = 11;
  localparam int unsigned CTL_SOFT   = 10;
  localparam int unsigned CTL_RELOAD = 5;
  localparam int unsigned CTL_STOP   = 4;

  // Prescale register fields.
  localparam int unsigned PSC_LSB    = 8;
  localparam int unsigned DIVIDE_DOWN_LOW_LSB   = 0;

  // Event status bits.
  localparam int unsigned EVT_ZERO   = 0;
  localparam int unsigned EVT_HALT   = 1;

  // Reset values.
  localparam logic [CNT_W-1:0] PERIOD_RST = 32'hffffffff;
  localparam logic [CNT_W-1:0] COUNT_RST  = 32'hffffffff;
  localparam logic [PSC_W-1:0] PSC_RST    = 8'h00;
  localparam logic [PSC_W-1:0] DIVIDE_DOWN_LOW_RST   = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST    = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO   = 16'h0000;

endpackage : ctc_pkg

// [test/testbench.sv]
// Self-checking bench for the CPU timer control block: register tasks and directed sequences.
// Assumes the block alone on one 250 MHz clock, driven through its plain register port.
module testbench import ctc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              CLOCK;
  logic              RESETN;
  logic              WR;
  logic              RD;
  logic              DEBUG_HALT;
  logic              IRQ;
  logic              RUNNING;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA;
  logic [DATA_W-1:0] RDATA;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] w;
  int                n;
  int                num_errors = 0;
  int                compares   = 0;

  ctc_timer ctc_timer_i (
    .CLOCK      (CLOCK),
    .RESETN     (RESETN),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .DEBUG_HALT (DEBUG_HALT),
    .RDATA      (RDATA),
    .IRQ        (IRQ),
    .RUNNING    (RUNNING)
  );

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp16(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp16

  task automatic cmp1(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : cmp1

  // Every access starts at a rising edge and ends 1 ns after the edge that takes it.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLOCK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge CLOCK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  task automatic chk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    cmp16(nm, exp, d);
  endtask : chk

  task automatic set_dbg(input logic lvl);
    @(posedge CLOCK);
    DEBUG_HALT <= lvl;
    #1;
  endtask : set_dbg

  task automatic idle(input int c);
    repeat (c) @(posedge CLOCK);
    #1;
  endtask : idle

  // Bounded wait on IRQ or RUNNING; the count of cycles spent comes back to the caller.
  task automatic wait_for(input logic sel_irq, input logic val, input int lim, output int cnt);
    cnt = 0;
    while ((sel_irq ? IRQ : RUNNING) !== val && cnt < lim) begin
      @(posedge CLOCK);
      #1;
      cnt++;
    end
    cmp1("wait", 1'b1, cnt < lim);
  endtask : wait_for

  initial begin
    repeat (5000) @(posedge CLOCK);
    num_errors++;
    print_verdict();
  end

  initial begin
    RESETN = 1'b0; WR = 1'b0; RD = 1'b0; DEBUG_HALT = 1'b0; ADDR = '0; WDATA = '0;
    repeat (16) @(posedge CLOCK);
    RESETN <= 1'b1;
    idle(2);
    cmp1("running", 1'b1, RUNNING);
    chk("control", IDX_CONTROL, 16'h0000);
    chk("prescale", IDX_PRESCALE, 16'h0000);
    chk("unmapped", 4'h8, 16'h0000);
    wr(4'h9, 16'hffff);
    wr(IDX_CONTROL, 16'h0010);
    wr(IDX_PERIOD_L, 16'h0005);
    wr(IDX_PERIOD_H, 16'h0000);
    wr(IDX_PRESCALE, 16'h0003);
    wr(IDX_CONTROL, 16'h0030);
    idle(2);
    cmp1("running", 1'b0, RUNNING);
    chk("control", IDX_CONTROL, 16'h0010);
    chk("count_l", IDX_COUNT_L, 16'h0005);
    chk("count_h", IDX_COUNT_H, 16'h0000);
    chk("prescale", IDX_PRESCALE, 16'h0303);
    wr(IDX_PERIOD_L, 16'h0007);
    wr(IDX_CONTROL, 16'h0010);
    chk("count_l", IDX_COUNT_L, 16'h0005);
    wr(IDX_PERIOD_L, 16'h0005);
    // Five steps of four cycles each, plus the one-cycle lag of IRQ.
    wr(IDX_CONTROL, 16'h4000);
    wait_for(1'b1, 1'b1, 40, n);
    cmp1("irq_time", 1'b1, n >= 19 && n <= 23);
    chk("control", IDX_CONTROL, 16'hc000);
    rd(IDX_COUNT_L, v);
    cmp1("reload", 1'b1, v <= 16'h0005);
    wr(IDX_CONTROL, 16'h4000);
    chk("control", IDX_CONTROL, 16'hc000);
    wr(IDX_CONTROL, 16'hc000);
    chk("control", IDX_CONTROL, 16'h4000);
    idle(1);
    cmp1("irq", 1'b0, IRQ);
    wr(IDX_CONTROL, 16'h0800);
    set_dbg(1'b1);
    idle(12);
    cmp1("running", 1'b1, RUNNING);
    rd(IDX_COUNT_L, v);
    idle(8);
    rd(IDX_COUNT_L, w);
    cmp1("free_count", 1'b1, v !== w);
    wr(IDX_CONTROL, 16'h0000);
    wait_for(1'b0, 1'b0, 20, n);
    cmp1("hard_time", 1'b1, n <= 8);
    rd(IDX_COUNT_L, v);
    idle(10);
    rd(IDX_COUNT_L, w);
    cmp16("hard_frozen", v, w);
    set_dbg(1'b0);
    wr(IDX_CONTROL, 16'h8400);
    idle(4);
    set_dbg(1'b1);
    wait_for(1'b0, 1'b0, 40, n);
    chk("count_l", IDX_COUNT_L, 16'h0000);
    chk("count_h", IDX_COUNT_H, 16'h0000);
    chk("control", IDX_CONTROL, 16'h8400);
    set_dbg(1'b0);
    wr(IDX_CONTROL, 16'h8000);
    chk("evt_stat", IDX_EVT_STAT, 16'h0003);
    idle(1);
    cmp1("irq", 1'b0, IRQ);
    wr(IDX_EVT_MASK, 16'h0001);
    wait_for(1'b1, 1'b1, 40, n);
    wr(IDX_EVT_MASK, 16'h0000);
    idle(2);
    cmp1("irq_masked", 1'b0, IRQ);
    chk("evt_stat", IDX_EVT_STAT, 16'h0001);
    chk("evt_clear", IDX_EVT_STAT, 16'h0000);
    print_verdict();
  end

endmodule : testbench
